// file: verilog/llfr_station.sv
`timescale 1ns/1ns
// Contract
// - station can send FRMR asking the peer to reset the link.
// - on received FRMR, start reset by RSET/SABME or disconnect by DISC; the code sends RSET or DISC only.
// - after sending FRMR the station enters the FRMR condition.
// - FRMR condition ends on SABME, DISC, DM or RSET sent or received.
// - other commands in FRMR condition resend FRMR with same information.
// - in FRMR condition no new I PDUs; received I and S discarded.
// - acknowledgment timer starts when FRMR is sent.
// - on timer expiry before SABME/DISC, resend FRMR and restart timer; the code gives up at the N2-th expiry, reports failure and enters ST_DISC.
// - extra FRMR while timer runs leaves the timer untouched.
// - accepted RSET is confirmed by UA at the earliest opportunity.
// - accepted RSET clears the receive variable V(R) to zero.
// - RSET sender clears V(S) to zero on receiving UA.
// - RSET clears rejection conditions except a reported invalid N(R).
// - invalid N(R) condition clears only by RSET from its detector; the code also clears it on a received SABME.
// - rejectable PDU during information transfer triggers an FRMR.
// - accepted SABME returns UA and clears V(S) and V(R).
// - awaiting reset, discard all PDUs except SABME and DISC commands; the code also acts on UA and DM responses.
module llfr_station #(
   parameter int ACK_TIME_US = 1000,
   parameter int N2 = 3,
   parameter int ACK_CYCLES = ACK_TIME_US * 1000 / llfr_pkg::CLK_PERIOD_NS
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_rx_valid,
   input wire logic [3:0] i_rx_type,
   input wire logic i_rx_cmd,
   input wire logic i_rx_reject,
   input wire logic i_rx_bad_nr,
   input wire logic [15:0] i_rx_ctrl,
   input wire logic [4:0] i_rx_cause,
   input wire logic i_tx_ready,
   input wire logic i_hl_data_req,
   input wire logic i_hl_connect,
   input wire logic i_hl_reset,
   input wire logic i_frmr_reply_disc,
   output logic o_tx_valid,
   output logic [3:0] o_tx_type,
   output logic [34:0] o_tx_frmr_info,
   output logic [6:0] o_vs,
   output logic [6:0] o_vr,
   output logic [1:0] o_link_state,
   output logic o_frmr_cond,
   output logic o_rej_nr,
   output logic o_ack_running,
   output logic o_fail,
   output logic o_rx_discard,
   output logic o_rx_deliver
);
   initial begin
      if (N2 < 1 || N2 > 255) $error("llfr_station: N2 out of 1..255");
      if (ACK_CYCLES < 1) $error("llfr_station: ACK_CYCLES below one");
   end

   localparam int RW = llfr_pkg::RETRY_W;
   localparam logic [RW-1:0] N2_LIM = RW'(N2);

   llfr_pkg::llfr_regs_t r_reg;
   llfr_pkg::llfr_regs_t r_next;

   logic c_sabme, c_disc, c_rset, c_dm, c_ua, c_frmr, c_ios, c_cmd;
   logic tim_start, tim_stop, tim_running, tim_expired;
   logic rx, clr_evt;

   llfr_rx_class u_class (
      .i_type(i_rx_type),
      .i_cmd(i_rx_cmd),
      .o_sabme(c_sabme),
      .o_disc(c_disc),
      .o_rset(c_rset),
      .o_dm(c_dm),
      .o_ua(c_ua),
      .o_frmr(c_frmr),
      .o_i_or_s(c_ios),
      .o_cmd(c_cmd)
   );

   llfr_ack_timer #(.CYCLES(ACK_CYCLES)) u_timer (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_start(tim_start),
      .i_stop(tim_stop),
      .o_running(tim_running),
      .o_expired(tim_expired)
   );

   function automatic logic waiting(input llfr_pkg::llfr_state_t s);
      return s == llfr_pkg::ST_FRMR || s == llfr_pkg::ST_RWAIT;
   endfunction

   assign rx = i_rx_valid;
   assign clr_evt = c_sabme || c_disc || c_rset || c_dm;

   always_comb begin
      r_next = r_reg;
      r_next.fail = 1'b0;
      r_next.discard = 1'b0;
      r_next.deliver = 1'b0;
      tim_start = 1'b0;
      if (r_reg.tx_valid && i_tx_ready) begin
         r_next.tx_valid = 1'b0;
      end
      // expiry first so a same-cycle clearing PDU overrides the retry
      if (tim_expired && waiting(r_reg.st)) begin
         r_next.retries = r_reg.retries + llfr_pkg::RETRY_ONE;
         if (r_reg.retries + llfr_pkg::RETRY_ONE >= N2_LIM) begin
            r_next.fail = 1'b1;
            r_next.st = llfr_pkg::ST_DISC;
            r_next.pend_frmr = 1'b0;
            r_next.pend_cmd = 1'b0;
         end else if (r_reg.st == llfr_pkg::ST_FRMR) begin
            r_next.pend_frmr = 1'b1;
         end else begin
            r_next.pend_cmd = 1'b1;
         end
      end
      if (rx && r_reg.st != llfr_pkg::ST_DISC) begin
         if (c_sabme) begin
            r_next.pend_ua = 1'b1;
            r_next.vs = llfr_pkg::SEQ_ZERO;
            r_next.vr = llfr_pkg::SEQ_ZERO;
            r_next.rej_any = 1'b0;
            r_next.rej_nr = 1'b0;
            r_next.pend_frmr = 1'b0;
            r_next.pend_cmd = 1'b0;
            r_next.st = llfr_pkg::ST_INFO;
         end else if (c_disc || c_dm) begin
            r_next.pend_ua = c_disc;
            r_next.pend_frmr = 1'b0;
            r_next.pend_cmd = 1'b0;
            r_next.st = llfr_pkg::ST_DISC;
         end else if (r_reg.st == llfr_pkg::ST_RWAIT) begin
            if (c_ua) begin
               r_next.vs = llfr_pkg::SEQ_ZERO;
               if (r_reg.cmd_kind == llfr_pkg::PDU_SABME) begin
                  r_next.vr = llfr_pkg::SEQ_ZERO;
               end
               r_next.pend_cmd = 1'b0;
               r_next.st = llfr_pkg::ST_INFO;
            end else begin
               r_next.discard = 1'b1;
            end
         end else if (c_rset) begin
            r_next.pend_ua = 1'b1;
            r_next.vr = llfr_pkg::SEQ_ZERO;
            // a peer RSET cannot clear our reported invalid N(R)
            r_next.rej_any = r_reg.rej_nr;
            r_next.pend_frmr = 1'b0;
            r_next.st = llfr_pkg::ST_INFO;
         end else if (c_frmr) begin
            r_next.pend_cmd = 1'b1;
            r_next.cmd_kind = i_frmr_reply_disc ? llfr_pkg::PDU_DISC :
                                                  llfr_pkg::PDU_RSET;
         end else if (r_reg.st == llfr_pkg::ST_FRMR) begin
            if (c_cmd) begin
               r_next.pend_frmr = 1'b1;
            end
            if (c_ios) begin
               r_next.discard = 1'b1;
            end
         end else if (i_rx_reject) begin
            r_next.frmr_info = {i_rx_ctrl, i_rx_cause, r_reg.vs, r_reg.vr};
            r_next.rej_any = 1'b1;
            r_next.rej_nr = i_rx_bad_nr;
            r_next.pend_frmr = 1'b1;
         end else if (c_ios && llfr_pkg::llfr_pdu_t'(i_rx_type) ==
                      llfr_pkg::PDU_I) begin
            r_next.deliver = 1'b1;
            r_next.vr = r_reg.vr + llfr_pkg::SEQ_ONE;
         end
      end else if (rx && c_sabme) begin
         r_next.pend_ua = 1'b1;
         r_next.vs = llfr_pkg::SEQ_ZERO;
         r_next.vr = llfr_pkg::SEQ_ZERO;
         r_next.rej_any = 1'b0;
         r_next.rej_nr = 1'b0;
         r_next.st = llfr_pkg::ST_INFO;
      end else if (rx) begin
         r_next.discard = 1'b1;
      end
      if (r_reg.st == llfr_pkg::ST_DISC && i_hl_connect) begin
         r_next.pend_cmd = 1'b1;
         r_next.cmd_kind = llfr_pkg::PDU_SABME;
      end else if (r_reg.st == llfr_pkg::ST_INFO && i_hl_reset &&
                   !r_next.pend_frmr) begin
         r_next.pend_cmd = 1'b1;
         r_next.cmd_kind = llfr_pkg::PDU_RSET;
      end
      // transmit slot: UA first, then FRMR, then commands, then data
      if (!r_next.tx_valid) begin
         if (r_next.pend_ua) begin
            r_next.pend_ua = 1'b0;
            r_next.tx_valid = 1'b1;
            r_next.tx_type = llfr_pkg::PDU_UA;
         end else if (r_next.pend_frmr) begin
            r_next.pend_frmr = 1'b0;
            r_next.tx_valid = 1'b1;
            r_next.tx_type = llfr_pkg::PDU_FRMR;
            if (r_next.st != llfr_pkg::ST_FRMR) begin
               r_next.retries = llfr_pkg::RETRY_ZERO;
            end
            r_next.st = llfr_pkg::ST_FRMR;
            tim_start = 1'b1;
         end else if (r_next.pend_cmd) begin
            r_next.pend_cmd = 1'b0;
            r_next.tx_valid = 1'b1;
            r_next.tx_type = r_next.cmd_kind;
            if (r_next.cmd_kind == llfr_pkg::PDU_DISC) begin
               r_next.st = llfr_pkg::ST_DISC;
            end else begin
               if (r_next.st != llfr_pkg::ST_RWAIT) begin
                  r_next.retries = llfr_pkg::RETRY_ZERO;
               end
               r_next.st = llfr_pkg::ST_RWAIT;
               tim_start = 1'b1;
            end
            if (r_next.cmd_kind == llfr_pkg::PDU_RSET) begin
               r_next.rej_any = 1'b0;
               r_next.rej_nr = 1'b0;
            end
         end else if (r_next.st == llfr_pkg::ST_INFO && i_hl_data_req) begin
            r_next.tx_valid = 1'b1;
            r_next.tx_type = llfr_pkg::PDU_I;
            r_next.vs = r_next.vs + llfr_pkg::SEQ_ONE;
         end
      end
      r_next.in_frmr = r_next.st == llfr_pkg::ST_FRMR;
   end

   // stop when leaving a state that waits on the peer
   assign tim_stop = waiting(r_reg.st) && !waiting(r_next.st);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         r_reg <= '0;
      end else if (i_ce) begin
         r_reg <= r_next;
      end
   end

   assign o_tx_valid = r_reg.tx_valid;
   assign o_tx_type = r_reg.tx_type;
   assign o_tx_frmr_info = r_reg.frmr_info;
   assign o_vs = r_reg.vs;
   assign o_vr = r_reg.vr;
   assign o_link_state = r_reg.st;
   assign o_frmr_cond = r_reg.in_frmr;
   assign o_rej_nr = r_reg.rej_nr;
   assign o_ack_running = tim_running;
   assign o_fail = r_reg.fail;
   assign o_rx_discard = r_reg.discard;
   assign o_rx_deliver = r_reg.deliver;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   logic ev_live, rx_frmr_cond;
   assign ev_live = i_ce && rx && r_reg.st != llfr_pkg::ST_DISC;
   assign rx_frmr_cond = ev_live && r_reg.st == llfr_pkg::ST_FRMR;

   chk_frmr_enters: assert property (
      $rose(o_tx_valid) && o_tx_type == llfr_pkg::PDU_FRMR |-> o_frmr_cond)
      else $error("FRMR sent without condition");
   chk_no_i_frmr: assert property (
      $rose(o_tx_valid) && o_tx_type == llfr_pkg::PDU_I |->
      !o_frmr_cond && !$past(o_frmr_cond))
      else $error("I PDU sent in FRMR condition");
   chk_frmr_discard: assert property (
      rx_frmr_cond && c_ios && !c_frmr |=> o_rx_discard)
      else $error("I or S not discarded");
   chk_frmr_resend: assert property (
      rx_frmr_cond && c_cmd && !clr_evt |=> r_reg.pend_frmr ||
      (o_tx_valid && o_tx_type == llfr_pkg::PDU_FRMR))
      else $error("FRMR not resent");
   chk_frmr_info_same: assert property (
      $rose(o_tx_valid) && o_tx_type == llfr_pkg::PDU_FRMR &&
      $past(o_frmr_cond) |-> $stable(o_tx_frmr_info))
      else $error("FRMR information changed");
   chk_frmr_leave: assert property (
      rx_frmr_cond && clr_evt |=> !o_frmr_cond)
      else $error("FRMR condition not cleared");
   chk_rset_ua: assert property (
      ev_live && c_rset && r_reg.st != llfr_pkg::ST_RWAIT && !c_sabme |=>
      o_vr == llfr_pkg::SEQ_ZERO ##0
      (r_reg.pend_ua || o_tx_type == llfr_pkg::PDU_UA))
      else $error("RSET not accepted");
   chk_rset_vs: assert property (
      ev_live && r_reg.st == llfr_pkg::ST_RWAIT && c_ua && !clr_evt |=>
      o_vs == llfr_pkg::SEQ_ZERO && o_link_state == llfr_pkg::ST_INFO)
      else $error("V(S) not cleared by UA");
   chk_timer_on_frmr: assert property (
      $rose(o_tx_valid) && o_tx_type == llfr_pkg::PDU_FRMR |-> o_ack_running)
      else $error("timer idle after FRMR");
   chk_fail_stop: assert property (
      o_fail |-> o_link_state == llfr_pkg::ST_DISC && !r_reg.pend_frmr &&
      r_reg.retries == N2_LIM)
      else $error("retry limit mishandled");
   chk_wait_discard: assert property (
      ev_live && r_reg.st == llfr_pkg::ST_RWAIT && !c_ua && !clr_evt |=>
      o_rx_discard)
      else $error("PDU kept while awaiting reset");
   chk_sabme_clear: assert property (
      i_ce && rx && c_sabme |=> o_vs == llfr_pkg::SEQ_ZERO &&
      o_vr == llfr_pkg::SEQ_ZERO && o_link_state == llfr_pkg::ST_INFO)
      else $error("SABME did not reset the link");
   chk_fail_pulse: assert property (
      o_fail && i_ce |=> !o_fail)
      else $error("failure report longer than one cycle");

   cov_frmr_sent: cover property (
      $rose(o_tx_valid) && o_tx_type == llfr_pkg::PDU_FRMR);
   cov_retry_fail: cover property ($rose(o_fail));
   cov_rset_done: cover property (
      ev_live && r_reg.st == llfr_pkg::ST_RWAIT && c_ua);
   cov_frmr_resend: cover property (rx_frmr_cond && c_cmd && !clr_evt);
endmodule

// file: verilog/llfr_pkg.sv
package llfr_pkg;
   // station clock
   localparam int CLK_PERIOD_NS = 10;
   // sequence numbers run modulo 128
   localparam int SEQ_W = 7;
   localparam logic [SEQ_W-1:0] SEQ_ZERO = 7'h00;
   localparam logic [SEQ_W-1:0] SEQ_ONE = 7'h01;
   localparam int RETRY_W = 8;
   localparam logic [RETRY_W-1:0] RETRY_ZERO = 8'h00;
   localparam logic [RETRY_W-1:0] RETRY_ONE = 8'h01;
   // rejected control field, cause bits, then V(S) and V(R)
   localparam int CTRL_W = 16;
   localparam int CAUSE_W = 5;
   localparam int INFO_W = CTRL_W + CAUSE_W + 2 * SEQ_W;
   localparam logic [INFO_W-1:0] INFO_ZERO = '0;

   typedef enum logic [3:0] {
      PDU_I = 4'h0,
      PDU_RR = 4'h1,
      PDU_RNR = 4'h2,
      PDU_REJ = 4'h3,
      PDU_SABME = 4'h4,
      PDU_DISC = 4'h5,
      PDU_DM = 4'h6,
      PDU_UA = 4'h7,
      PDU_FRMR = 4'h8,
      PDU_RSET = 4'h9,
      PDU_OTHER = 4'hF
   } llfr_pdu_t;

   typedef enum logic [1:0] {
      ST_DISC = 2'b00,
      ST_INFO = 2'b01,
      ST_FRMR = 2'b10,
      ST_RWAIT = 2'b11
   } llfr_state_t;

   typedef struct packed {
      llfr_state_t st;
      logic in_frmr;
      logic [SEQ_W-1:0] vs;
      logic [SEQ_W-1:0] vr;
      logic pend_ua;
      logic pend_frmr;
      logic pend_cmd;
      llfr_pdu_t cmd_kind;
      logic tx_valid;
      llfr_pdu_t tx_type;
      logic [INFO_W-1:0] frmr_info;
      logic [RETRY_W-1:0] retries;
      logic rej_any;
      logic rej_nr;
      logic fail;
      logic discard;
      logic deliver;
   } llfr_regs_t;
endpackage

// file: verilog/llfr_ack_timer.sv
`timescale 1ns/1ns
module llfr_ack_timer #(
   parameter int CYCLES = 100000
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic i_stop,
   output logic o_running,
   output logic o_expired
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES);
   localparam logic [CW-1:0] ONE = CW'(1);

   initial begin
      if (CYCLES < 1) $error("llfr_ack_timer: CYCLES must be positive");
   end

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic running;
      logic expired;
   } llfr_tim_t;

   llfr_tim_t t_reg;
   llfr_tim_t t_next;

   always_comb begin
      t_next = t_reg;
      t_next.expired = 1'b0;
      if (i_stop) begin
         t_next.running = 1'b0;
      end else if (t_reg.running) begin
         // a start while running is ignored so the count is never stretched
         if (t_reg.cnt == ONE) begin
            t_next.running = 1'b0;
            t_next.expired = 1'b1;
         end else begin
            t_next.cnt = t_reg.cnt - ONE;
         end
      end else if (i_start) begin
         t_next.running = 1'b1;
         t_next.cnt = LOAD;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         t_reg <= '0;
      end else if (i_ce) begin
         t_reg <= t_next;
      end
   end

   assign o_running = t_reg.running;
   assign o_expired = t_reg.expired;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   chk_start_ignored: assert property (
      i_ce && t_reg.running && i_start && !i_stop && t_reg.cnt != ONE |=>
      t_reg.cnt == $past(t_reg.cnt) - ONE)
      else $error("timer disturbed by start while running");
endmodule

// file: verilog/llfr_rx_class.sv
`timescale 1ns/1ns
module llfr_rx_class (
   input wire logic [3:0] i_type,
   input wire logic i_cmd,
   output logic o_sabme,
   output logic o_disc,
   output logic o_rset,
   output logic o_dm,
   output logic o_ua,
   output logic o_frmr,
   output logic o_i_or_s,
   output logic o_cmd
);
   llfr_pkg::llfr_pdu_t t;

   always_comb begin
      t = llfr_pkg::llfr_pdu_t'(i_type);
      o_sabme = i_cmd && t == llfr_pkg::PDU_SABME;
      o_disc = i_cmd && t == llfr_pkg::PDU_DISC;
      o_rset = i_cmd && t == llfr_pkg::PDU_RSET;
      o_dm = !i_cmd && t == llfr_pkg::PDU_DM;
      o_ua = !i_cmd && t == llfr_pkg::PDU_UA;
      o_frmr = !i_cmd && t == llfr_pkg::PDU_FRMR;
      o_i_or_s = t == llfr_pkg::PDU_I || t == llfr_pkg::PDU_RR ||
                 t == llfr_pkg::PDU_RNR || t == llfr_pkg::PDU_REJ;
      o_cmd = i_cmd;
   end
endmodule

// file: sim/llfr_peer_model.sv
`timescale 1ns/1ns
module llfr_peer_model (
   input wire logic i_clk,
   input wire logic i_tx_valid,
   input wire logic [3:0] i_tx_type,
   input wire logic [34:0] i_tx_info,
   input wire logic [3:0] i_stall,
   output logic o_ready,
   output logic o_rx_valid,
   output logic [3:0] o_rx_type,
   output logic o_rx_cmd,
   output logic o_rx_reject,
   output logic o_rx_bad_nr,
   output logic [15:0] o_rx_ctrl,
   output logic [4:0] o_rx_cause
);
   logic [3:0] wait_cnt;
   logic [3:0] got_type[$];
   logic [34:0] got_info[$];
   initial begin
      o_ready = 1'b0;
      wait_cnt = 4'h0;
      o_rx_valid = 1'b0;
      {o_rx_type, o_rx_cmd, o_rx_reject, o_rx_bad_nr} = 7'h00;
      {o_rx_ctrl, o_rx_cause} = 21'h000000;
   end
   // a nonzero stall models a slow transmitter holding off each pdu
   always @(posedge i_clk) begin
      if (i_tx_valid && o_ready) begin
         got_type.push_back(i_tx_type);
         got_info.push_back(i_tx_info);
         wait_cnt <= 4'h0;
         o_ready <= (i_stall == 4'h0);
      end else begin
         wait_cnt <= i_tx_valid ? wait_cnt + 4'h1 : 4'h0;
         o_ready <= (i_stall == 4'h0) || (i_tx_valid && wait_cnt >= i_stall);
      end
   end
   // one pdu per call; idle lines show inverted garbage, not the last pdu
   task automatic send(input logic [3:0] t, input logic c, input logic r,
                       input logic b, input logic [15:0] f,
                       input logic [4:0] k);
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      {o_rx_type, o_rx_cmd, o_rx_reject, o_rx_bad_nr} <= {t, c, r, b};
      {o_rx_ctrl, o_rx_cause} <= {f, k};
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      {o_rx_type, o_rx_cmd, o_rx_reject, o_rx_bad_nr} <= ~{t, c, r, b};
      {o_rx_ctrl, o_rx_cause} <= ~{f, k};
      #1;
   endtask
endmodule

// file: sim/link_frame_reject_reset_bench.sv
`timescale 1ns/1ns
module link_frame_reject_reset_bench;
   localparam int ACK = 20;
   localparam int NRET = 3;
   logic clk, reset, ce, tx_ready, hl_data_req, hl_connect, hl_reset;
   logic reply_disc, rx_valid, rx_cmd, rx_reject, rx_bad_nr, tx_valid;
   logic [3:0] rx_type, stall, tx_type;
   logic [15:0] rx_ctrl;
   logic [4:0] rx_cause;
   logic frmr_cond, rej_nr, ack_running, fail, discard, deliver;
   logic [34:0] frmr_info, last_info;
   logic [6:0] vs, vr;
   logic [1:0] link_state;
   int fail_count = 0;
   int checks = 0;

   llfr_station #(.ACK_CYCLES(ACK), .N2(NRET)) dut_u (
      .i_clk(clk), .i_reset(reset), .i_ce(ce), .i_rx_valid(rx_valid),
      .i_rx_type(rx_type), .i_rx_cmd(rx_cmd), .i_rx_reject(rx_reject),
      .i_rx_bad_nr(rx_bad_nr), .i_rx_ctrl(rx_ctrl), .i_rx_cause(rx_cause),
      .i_tx_ready(tx_ready), .i_hl_data_req(hl_data_req),
      .i_hl_connect(hl_connect), .i_hl_reset(hl_reset),
      .i_frmr_reply_disc(reply_disc), .o_tx_valid(tx_valid),
      .o_tx_type(tx_type), .o_tx_frmr_info(frmr_info), .o_vs(vs),
      .o_vr(vr), .o_link_state(link_state), .o_frmr_cond(frmr_cond),
      .o_rej_nr(rej_nr), .o_ack_running(ack_running), .o_fail(fail),
      .o_rx_discard(discard), .o_rx_deliver(deliver));

   llfr_peer_model peer_u (
      .i_clk(clk), .i_tx_valid(tx_valid), .i_tx_type(tx_type),
      .i_tx_info(frmr_info), .i_stall(stall), .o_ready(tx_ready),
      .o_rx_valid(rx_valid), .o_rx_type(rx_type), .o_rx_cmd(rx_cmd),
      .o_rx_reject(rx_reject), .o_rx_bad_nr(rx_bad_nr),
      .o_rx_ctrl(rx_ctrl), .o_rx_cause(rx_cause));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic final_report();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check_val(input logic [34:0] got, input logic [34:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_pdu(input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t pdu got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_tx(input logic [3:0] exp);
      int n = 0;
      while (peer_u.got_type.size() == 0 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (peer_u.got_type.size() == 0) begin
         fail_count++;
         final_report();
      end else begin
         check_pdu(peer_u.got_type.pop_front(), exp);
         last_info = peer_u.got_info.pop_front();
      end
   endtask

   task automatic rx(input logic [3:0] t, input logic c);
      peer_u.send(t, c, 1'b0, 1'b0, 16'h0000, 5'h00);
   endtask

   task automatic flush();
      repeat (4) @(posedge clk);
      #1;
      peer_u.got_type.delete();
      peer_u.got_info.delete();
   endtask

   task automatic connect();
      @(posedge clk) hl_connect <= 1'b1;
      wait_tx(llfr_pkg::PDU_SABME);
      @(posedge clk) hl_connect <= 1'b0;
      rx(llfr_pkg::PDU_UA, 1'b0);
      check_val(link_state, 2'h1);
      check_val({vs, vr}, 14'h0000);
   endtask

   task automatic t_rset_rx();
      connect();
      // with the enable low a pdu must leave no trace
      @(posedge clk) ce <= 1'b0;
      rx(llfr_pkg::PDU_I, 1'b1);
      check_val({vr, deliver}, 8'h00);
      @(posedge clk) ce <= 1'b1;
      rx(llfr_pkg::PDU_I, 1'b1);
      check_val(deliver, 1'b1);
      check_val(vr, 7'h01);
      rx(llfr_pkg::PDU_RSET, 1'b1);
      check_val(vr, 7'h00);
      check_val(tx_valid, 1'b1);
      wait_tx(llfr_pkg::PDU_UA);
      rx(llfr_pkg::PDU_I, 1'b1);
      rx(llfr_pkg::PDU_SABME, 1'b1);
      check_val({vs, vr}, 14'h0000);
      wait_tx(llfr_pkg::PDU_UA);
   endtask

   task automatic t_frmr_timeout();
      int n = 0;
      logic [34:0] cnt = 35'h0;
      logic [34:0] exp = {16'hA5C3, 5'h15, 7'h00, 7'h01};
      rx(llfr_pkg::PDU_I, 1'b1);
      peer_u.send(llfr_pkg::PDU_I, 1'b1, 1'b1, 1'b0, 16'hA5C3, 5'h15);
      check_val(frmr_cond, 1'b1);
      check_val(ack_running, 1'b1);
      wait_tx(llfr_pkg::PDU_FRMR);
      check_val(last_info, exp);
      @(posedge clk) hl_data_req <= 1'b1;
      rx(llfr_pkg::PDU_RR, 1'b1);
      check_val(discard, 1'b1);
      check_val(ack_running, 1'b1);
      wait_tx(llfr_pkg::PDU_FRMR);
      check_val(last_info, exp);
      // any I pdu slipping out here shows up as a pdu mismatch
      while (fail !== 1'b1 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
         if (peer_u.got_type.size() > 0) begin
            wait_tx(llfr_pkg::PDU_FRMR);
            check_val(last_info, exp);
            cnt++;
         end
      end
      if (n >= 300) begin
         fail_count++;
         final_report();
      end
      check_val(fail, 1'b1);
      check_val(cnt, 35'(NRET - 1));
      check_val(link_state, 2'h0);
      @(posedge clk) hl_data_req <= 1'b0;
      flush();
   endtask

   task automatic t_frmr_clear();
      llfr_pkg::llfr_pdu_t kinds[4] = '{llfr_pkg::PDU_SABME,
         llfr_pkg::PDU_DISC, llfr_pkg::PDU_DM, llfr_pkg::PDU_RSET};
      for (int i = 0; i < 4; i++) begin
         if (link_state !== 2'h1) connect();
         peer_u.send(llfr_pkg::PDU_I, 1'b1, 1'b1, 1'b0, 16'h1234, 5'h01);
         wait_tx(llfr_pkg::PDU_FRMR);
         rx(kinds[i], kinds[i] != llfr_pkg::PDU_DM);
         check_val(frmr_cond, 1'b0);
         flush();
      end
   endtask

   task automatic t_bad_nr();
      @(posedge clk) stall <= 4'h2;
      if (link_state !== 2'h1) connect();
      peer_u.send(llfr_pkg::PDU_I, 1'b1, 1'b1, 1'b1, 16'h0F0F, 5'h08);
      check_val(rej_nr, 1'b1);
      wait_tx(llfr_pkg::PDU_FRMR);
      rx(llfr_pkg::PDU_RSET, 1'b1);
      check_val(frmr_cond, 1'b0);
      check_val(rej_nr, 1'b1);
      wait_tx(llfr_pkg::PDU_UA);
      @(posedge clk) hl_data_req <= 1'b1;
      @(posedge clk) hl_data_req <= 1'b0;
      wait_tx(llfr_pkg::PDU_I);
      check_val(vs, 7'h01);
      rx(llfr_pkg::PDU_FRMR, 1'b0);
      wait_tx(llfr_pkg::PDU_RSET);
      check_val(link_state, 2'h3);
      rx(llfr_pkg::PDU_I, 1'b1);
      check_val(discard, 1'b1);
      rx(llfr_pkg::PDU_UA, 1'b0);
      check_val(vs, 7'h00);
      check_val(rej_nr, 1'b0);
      @(posedge clk) reply_disc <= 1'b1;
      rx(llfr_pkg::PDU_FRMR, 1'b0);
      wait_tx(llfr_pkg::PDU_DISC);
      check_val(link_state, 2'h0);
   endtask

   initial begin
      reset = 1'b1;
      ce = 1'b1;
      stall = 4'h0;
      {hl_data_req, hl_connect, hl_reset, reply_disc} = 4'h0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      check_val(link_state, 2'h0);
      check_val({tx_valid, frmr_cond, fail}, 3'h0);
      t_rset_rx();
      t_frmr_timeout();
      t_frmr_clear();
      t_bad_nr();
      final_report();
   end
endmodule
